/* File: src/dcp_defines.svh */
// Status code and size constants for the DMA command protocol engine
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH
`define DCP_MAX_FIS_DWORDS 2048
`define DCP_CNT_W 12
`define DCP_WORD_W 32
`define DCP_STATUS_W 8
`define DCP_ERROR_W 8
`define DCP_STAT_OK 8'h50
`define DCP_STAT_ERR 8'h51
`define DCP_ERR_ABORT 8'h04
`define DCP_BUF_DEPTH 2
`endif

/* File: src/dcp_pkg.sv */
// Types shared by the DMA command protocol engine
package dcp_pkg;
  typedef enum logic [7:0] {
    CMD_IDLE = 8'h01,
    IN_PREP = 8'h02,
    IN_SEND_DATA = 8'h04,
    IN_SEND_STATUS = 8'h08,
    OUT_WAIT = 8'h10,
    ACT_SEND = 8'h20,
    OUT_RECV = 8'h40,
    OUT_SEND_STATUS = 8'h80
  } dcp_state_e;
  // Request for one data frame to the transport layer
  typedef struct packed {
    logic [11:0] dwordCount;
  } dcp_frame_req_s;
  // Register Device to Host status frame content
  typedef struct packed {
    logic intBit;
    logic [7:0] status;
    logic [7:0] error;
  } dcp_status_fis_s;
endpackage : dcp_pkg

/* File: src/dcp_skid_buffer.sv */
// Two-entry valid/ready buffer for data words
`timescale 1ns/1ps
`include "dcp_defines.svh"
module dcp_skid_buffer #(
  parameter int WIDTH = `DCP_WORD_W,
  parameter int DEPTH = `DCP_BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic doWrite;
  logic doRead;

  // Full and empty straight from the occupancy count
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // Storage is written without reset; only pointers and count carry state
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + AW'(1);
      end
      if (doRead) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule : dcp_skid_buffer

/* File: src/dcp_dma_engine.sv */
// DMA data-in and data-out command layer state machine
//
// Behaviour
// - DMA-in command or more frames needed: enter inbound prepare, stage data.
// - Inbound prepare with data ready moves to inbound send-data.
// - Inbound prepare with all data sent or error moves to send-status.
// - Send-data requests one data frame, never above 2048 Dwords.
// - Data frame transferred returns to inbound prepare.
// - Send-status requests a status frame with interrupt bit set.
// - Status frame transmitted returns the command layer to idle.
// - DMA-out raises one interrupt, only after all data transferred or on error.
// - DMA-out command or more frames needed: enter outbound wait.
// - Outbound wait, ready to accept, moves to activate-sending.
// - Outbound wait with all data received or error moves to send-status.
// - Activate-sending requests a DMA Activate frame.
// - Activate frame transferred moves to outbound receive-data.
// - Receive-data takes one frame, then returns to outbound wait.
`timescale 1ns/1ps
`include "dcp_defines.svh"
module dcp_dma_engine
  import dcp_pkg::*;
#(
  parameter int MAX_FIS_DWORDS = `DCP_MAX_FIS_DWORDS,
  parameter int WORD_W = `DCP_WORD_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  // Command start from the command decoder
  input wire logic cmdStart,
  input wire logic cmdIsOut,
  input wire logic [31:0] cmdDwords,
  output logic cmdBusy,
  // Device media side: inbound data source
  input wire logic [WORD_W-1:0] srcData,
  input wire logic srcValid,
  output logic srcReady,
  // Device media side: outbound data sink
  output logic [WORD_W-1:0] sinkData,
  output logic sinkValid,
  input wire logic sinkReady,
  input wire logic sinkReadyForFrame,
  input wire logic deviceError,
  // Transport: data frame transmit
  output logic txDataReq,
  output dcp_frame_req_s txDataInfo,
  output logic [WORD_W-1:0] txData,
  output logic txDataValid,
  input wire logic txDataReady,
  input wire logic txDataDone,
  // Transport: DMA Activate frame
  output logic txActReq,
  input wire logic txActDone,
  // Transport: received data frame
  input wire logic [WORD_W-1:0] rxData,
  input wire logic rxValid,
  output logic rxReady,
  input wire logic rxDone,
  input wire logic rxError,
  // Transport: status frame
  output logic txStatusReq,
  output dcp_status_fis_s txStatusInfo,
  input wire logic txStatusDone
);
  localparam int CW = `DCP_CNT_W + 1;

  // -----------------------------------------------------------------
  // State and counters
  // -----------------------------------------------------------------
  dcp_state_e state_r;
  dcp_state_e state_nxt;
  logic [31:0] remain_r;
  logic [CW-1:0] frameLen_r;
  logic [CW-1:0] frameCnt_r;
  logic error_r;
  logic [CW-1:0] chunk;
  logic inWord;
  logic outWord;
  logic bufInReady;
  logic bufOutValid;
  logic [WORD_W-1:0] bufOutData;
  logic dataXfer;
  logic errNow;

  // Frame size capped at the per-frame Dword limit
  assign chunk = (remain_r > 32'(MAX_FIS_DWORDS)) ? CW'(MAX_FIS_DWORDS)
                                                 : CW'(remain_r);
  assign dataXfer = (state_r == IN_SEND_DATA) || (state_r == OUT_RECV);
  assign errNow = dataXfer && (deviceError || (state_r == OUT_RECV && rxError));

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  // Plain combinational case keeps every transition visible in one place
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CMD_IDLE: begin
        if (cmdStart) begin
          state_nxt = cmdIsOut ? OUT_WAIT : IN_PREP;
        end
      end
      IN_PREP: begin
        if (error_r || remain_r == 32'h0000_0000) begin
          state_nxt = IN_SEND_STATUS;
        end else if (srcValid) begin
          state_nxt = IN_SEND_DATA;
        end
      end
      IN_SEND_DATA: begin
        if (errNow || txDataDone) begin
          state_nxt = IN_PREP;
        end
      end
      OUT_WAIT: begin
        if (error_r || remain_r == 32'h0000_0000) begin
          state_nxt = OUT_SEND_STATUS;
        end else if (sinkReadyForFrame) begin
          state_nxt = ACT_SEND;
        end
      end
      ACT_SEND: begin
        if (txActDone) begin
          state_nxt = OUT_RECV;
        end
      end
      OUT_RECV: begin
        if (errNow || rxDone) begin
          state_nxt = OUT_WAIT;
        end
      end
      IN_SEND_STATUS, OUT_SEND_STATUS: begin
        if (txStatusDone) begin
          state_nxt = CMD_IDLE;
        end
      end
      default: state_nxt = CMD_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= CMD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Transfer bookkeeping
  // -----------------------------------------------------------------
  // Remaining Dwords shrink by the length of each finished frame
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      remain_r <= '0;
      frameLen_r <= '0;
    end else if (state_r == CMD_IDLE && cmdStart) begin
      remain_r <= cmdDwords;
      frameLen_r <= '0;
    end else if ((state_r == IN_PREP && state_nxt == IN_SEND_DATA) ||
                 (state_r == OUT_WAIT && state_nxt == ACT_SEND)) begin
      frameLen_r <= chunk;
    end else if ((state_r == IN_SEND_DATA && txDataDone && !errNow) ||
                 (state_r == OUT_RECV && rxDone && !errNow)) begin
      remain_r <= remain_r - 32'(frameLen_r);
    end
  end

  // Words moved within the current frame
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frameCnt_r <= '0;
    end else if (!dataXfer) begin
      frameCnt_r <= '0;
    end else if (inWord || outWord) begin
      frameCnt_r <= frameCnt_r + CW'(1);
    end
  end

  // Error latches past the end of the command; cleared only at a fresh start
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      error_r <= 1'b0;
    end else if (state_r == CMD_IDLE && cmdStart) begin
      error_r <= 1'b0;
    end else if (errNow) begin
      error_r <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Inbound data path: source straight to transport, word-capped
  // -----------------------------------------------------------------
  assign inWord = (state_r == IN_SEND_DATA) && srcValid && txDataReady &&
                  (frameCnt_r < frameLen_r);
  assign srcReady = (state_r == IN_SEND_DATA) && txDataReady && (frameCnt_r < frameLen_r);
  assign txDataValid = (state_r == IN_SEND_DATA) && srcValid && (frameCnt_r < frameLen_r);
  assign txData = srcData;
  assign txDataReq = (state_r == IN_SEND_DATA);
  assign txDataInfo.dwordCount = frameLen_r[`DCP_CNT_W-1:0] == '0 ?
                                 `DCP_CNT_W'(0) : frameLen_r[`DCP_CNT_W-1:0];

  // -----------------------------------------------------------------
  // Outbound data path: transport into the two-entry buffer
  // -----------------------------------------------------------------
  // Buffer absorbs a sink stall so no received word is dropped
  assign rxReady = (state_r == OUT_RECV) && bufInReady;
  assign outWord = (state_r == OUT_RECV) && rxValid && bufInReady;

  dcp_skid_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(`DCP_BUF_DEPTH)
  ) u_rxBuf (
    .clk_sys(clk_sys),
    .reset(reset),
    .inData(rxData),
    .inValid(outWord),
    .inReady(bufInReady),
    .outData(bufOutData),
    .outValid(bufOutValid),
    .outReady(sinkReady)
  );
  assign sinkData = bufOutData;
  assign sinkValid = bufOutValid;

  // -----------------------------------------------------------------
  // Activate and status frames
  // -----------------------------------------------------------------
  assign txActReq = (state_r == ACT_SEND);
  assign txStatusReq = (state_r == IN_SEND_STATUS) || (state_r == OUT_SEND_STATUS);
  // Interrupt only rides on the single closing status frame
  assign txStatusInfo.intBit = 1'b1;
  assign txStatusInfo.status = error_r ? `DCP_STAT_ERR : `DCP_STAT_OK;
  assign txStatusInfo.error = error_r ? `DCP_ERR_ABORT : 8'h00;
  assign cmdBusy = (state_r != CMD_IDLE);

  // -----------------------------------------------------------------
  // Check helpers
  // -----------------------------------------------------------------
  // Closing status frames since the last start; saturates so it never wraps
  logic [1:0] statusSent_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      statusSent_r <= 2'h0;
    end else if (state_r == CMD_IDLE && cmdStart) begin
      statusSent_r <= 2'h0;
    end else if (txStatusReq && txStatusDone && statusSent_r != 2'h3) begin
      statusSent_r <= statusSent_r + 2'h1;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_frame_limit: assert property (@(posedge clk_sys) disable iff (reset)
    txDataReq |-> (frameLen_r <= CW'(MAX_FIS_DWORDS) && frameLen_r != '0))
    else $error("data frame length out of range");
  chk_prep_to_send: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == IN_PREP && !error_r && remain_r != 0 && srcValid) |=> state_r == IN_SEND_DATA)
    else $error("inbound prepare did not advance to send");
  chk_in_done_status: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == IN_PREP && (error_r || remain_r == 0)) |=> state_r == IN_SEND_STATUS)
    else $error("inbound finish did not go to status");
  chk_data_return: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == IN_SEND_DATA && txDataDone) |=> state_r == IN_PREP)
    else $error("data frame done did not return to prepare");
  chk_status_int: assert property (@(posedge clk_sys) disable iff (reset)
    txStatusReq |-> txStatusInfo.intBit && !txDataReq && !txActReq)
    else $error("status frame without interrupt bit");
  chk_status_idle: assert property (@(posedge clk_sys) disable iff (reset)
    (txStatusReq && txStatusDone) |=> state_r == CMD_IDLE && !cmdBusy)
    else $error("status done did not return to idle");
  chk_out_activate: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == OUT_WAIT && !error_r && remain_r != 0 && sinkReadyForFrame) |=> txActReq)
    else $error("ready outbound did not request activate");
  chk_act_to_recv: assert property (@(posedge clk_sys) disable iff (reset)
    (txActReq && txActDone) |=> (state_r == OUT_RECV) ##0 !txActReq)
    else $error("activate done did not enter receive");
  chk_recv_return: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == OUT_RECV && rxDone) |=> state_r == OUT_WAIT)
    else $error("receive done did not return to wait");
  chk_err_status: assert property (@(posedge clk_sys) disable iff (reset)
    (errNow && state_r == OUT_RECV) |=> ##1
      (state_r == OUT_SEND_STATUS && txStatusInfo.status == `DCP_STAT_ERR))
    else $error("error did not lead to error status");

  // -----------------------------------------------------------------
  // Command-level checks
  // -----------------------------------------------------------------
  // Entry into each machine on a fresh command
  chk_in_start: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == CMD_IDLE && cmdStart && !cmdIsOut) |=> state_r == IN_PREP)
    else $error("data-in command did not enter prepare");
  chk_out_start: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == CMD_IDLE && cmdStart && cmdIsOut) |=> state_r == OUT_WAIT)
    else $error("data-out command did not enter wait");
  // Idle drives no request and takes no data
  chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == CMD_IDLE) |-> !txDataReq && !txActReq && !txStatusReq && !srcReady && !rxReady)
    else $error("idle machine drove a request");
  // Prepare waits for source data rather than sending an empty frame
  chk_prep_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == IN_PREP && !error_r && remain_r != 0 && !srcValid) |=>
      state_r == IN_PREP)
    else $error("prepare left without data");
  // Words per frame and the remaining count stay consistent
  chk_frame_words: assert property (@(posedge clk_sys) disable iff (reset)
    dataXfer |-> frameCnt_r <= frameLen_r)
    else $error("frame words passed frame length");
  chk_remain_drop: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == IN_SEND_DATA && txDataDone && !errNow) |=>
      remain_r == $past(remain_r) - 32'($past(frameLen_r)))
    else $error("remaining count did not drop by frame length");
  // Outbound wait holds until the sink can take a frame
  chk_wait_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == OUT_WAIT && !error_r && remain_r != 0 && !sinkReadyForFrame) |=>
      state_r == OUT_WAIT)
    else $error("outbound wait left without sink room");
  chk_out_done_status: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == OUT_WAIT && (error_r || remain_r == 0)) |=> state_r == OUT_SEND_STATUS)
    else $error("outbound finish did not go to status");
  chk_act_request: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ACT_SEND) |-> txActReq && !txDataReq && !txStatusReq && !rxReady)
    else $error("activate state without lone activate request");
  chk_act_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (txActReq && !txActDone) |=> txActReq)
    else $error("activate request dropped early");
  chk_recv_only: assert property (@(posedge clk_sys) disable iff (reset)
    rxReady |-> state_r == OUT_RECV)
    else $error("received data taken outside receive");
  // One interrupt per command; on data-out without error only once every Dword arrived
  chk_single_int: assert property (@(posedge clk_sys) disable iff (reset)
    (txStatusReq && txStatusDone) |-> statusSent_r == 2'h0)
    else $error("second interrupt frame in one command");
  chk_out_int_done: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == OUT_SEND_STATUS && !error_r) |-> remain_r == 32'h0000_0000)
    else $error("data-out interrupt before all data arrived");
  chk_status_ok: assert property (@(posedge clk_sys) disable iff (reset)
    (txStatusReq && !error_r) |-> txStatusInfo.status == `DCP_STAT_OK && txStatusInfo.error == 8'h00)
    else $error("clean command reported an error");
  chk_in_err_status: assert property (@(posedge clk_sys) disable iff (reset)
    (errNow && state_r == IN_SEND_DATA) |=> ##1
      (state_r == IN_SEND_STATUS && txStatusInfo.status == `DCP_STAT_ERR))
    else $error("inbound error did not lead to error status");
endmodule : dcp_dma_engine

/* File: dv/dcp_transport_model.sv */
// Transport layer model facing the DMA command engine
`timescale 1ns/1ps
module dcp_transport_model
  import dcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic txDataReq,
  input wire dcp_frame_req_s txDataInfo,
  input wire logic [31:0] txData,
  input wire logic txDataValid,
  output logic txDataReady,
  output logic txDataDone,
  input wire logic txActReq,
  output logic txActDone,
  output logic [31:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output logic rxDone,
  output logic rxError,
  input wire logic txStatusReq,
  input wire dcp_status_fis_s txStatusInfo,
  output logic txStatusDone,
  input wire logic [11:0] rxLen,
  input wire logic rxErrInject,
  output int dataWords,
  output int frames,
  output int maxLen,
  output int actCount,
  output int statusCount,
  output logic [31:0] lastTx,
  output dcp_status_fis_s lastStatus
);
  int frameCnt;
  int rxTotal;
  int rxFrame;
  int reqLen;
  // ------------------------------------------------------------
  // Data frame sink
  // ------------------------------------------------------------
  assign reqLen = (txDataInfo.dwordCount == 12'h000) ? 2048 : int'(txDataInfo.dwordCount);
  // Host-side fault on the incoming frame, raised by the bench
  assign rxError = rxErrInject;
  // Released data lines show the inverse so stale words never match
  assign rxData = rxValid ? 32'hA5000000 + rxTotal : ~(32'hA5000000 + rxTotal);
  // Stalls every other cycle; an aborted frame clears the word count
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txDataReady <= 1'b0;
      txDataDone <= 1'b0;
      frameCnt <= 0;
      dataWords <= 0;
      frames <= 0;
      maxLen <= 0;
      lastTx <= '0;
    end else begin
      txDataReady <= txDataReq && !txDataReady;
      txDataDone <= txDataReq && !txDataDone && frameCnt == reqLen;
      if (!txDataReq || txDataDone) begin
        frameCnt <= 0;
      end else if (txDataValid && txDataReady) begin
        frameCnt <= frameCnt + 1;
        dataWords <= dataWords + 1;
        lastTx <= txData;
      end
      if (txDataReq && reqLen > maxLen) maxLen <= reqLen;
      if (txDataDone) frames <= frames + 1;
    end
  end
  // ------------------------------------------------------------
  // Activation, host data frame and status frame
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txActDone <= 1'b0;
      rxValid <= 1'b0;
      rxDone <= 1'b0;
      rxFrame <= 0;
      txStatusDone <= 1'b0;
      rxTotal <= 0;
      actCount <= 0;
      statusCount <= 0;
      lastStatus <= '0;
    end else begin
      txActDone <= txActReq && !txActDone && !rxValid;
      if (txActDone) actCount <= actCount + 1;
      if (txActDone) rxValid <= 1'b1;
      rxDone <= 1'b0;
      if (rxValid && rxReady) begin
        rxTotal <= rxTotal + 1;
        rxFrame <= rxFrame + 1;
        if (rxFrame + 1 == int'(rxLen)) begin
          rxValid <= 1'b0;
          rxDone <= 1'b1;
          rxFrame <= 0;
        end
      end
      // A host-side abort drops the rest of the frame
      if (rxErrInject) begin
        rxValid <= 1'b0;
        rxFrame <= 0;
      end
      txStatusDone <= txStatusReq && !txStatusDone;
      if (txStatusReq && !txStatusDone) begin
        statusCount <= statusCount + 1;
        lastStatus <= txStatusInfo;
      end
    end
  end
endmodule : dcp_transport_model

/* File: dv/testbench.sv */
// Self-checking bench for the DMA command engine
`timescale 1ns/1ps
module testbench;
  import dcp_pkg::*;
  logic clk_sys = 0, reset = 1, cmdStart = 0, cmdIsOut = 0, srcValid = 0, sinkReady = 0;
  logic sinkReadyForFrame = 1, deviceError = 0, rxErrInject = 0;
  logic [31:0] cmdDwords = '0, srcData = '0;
  logic [11:0] rxLen = 12'h004;
  logic cmdBusy, srcReady, sinkValid, txDataReq, txDataValid, txDataReady, txDataDone;
  logic txActReq, txActDone, rxValid, rxReady, rxDone, rxError, txStatusReq, txStatusDone;
  logic [31:0] sinkData, txData, rxData, lastTx;
  dcp_frame_req_s txDataInfo;
  dcp_status_fis_s txStatusInfo, lastStatus;
  int dataWords, frames, maxLen, actCount, statusCount;
  int miscompares = 0, num_checks = 0, srcTaken = 0, sinkCnt = 0, sinkBad = 0;
  always #25 clk_sys = ~clk_sys;
  dcp_dma_engine DUT (.clk_sys, .reset, .cmdStart, .cmdIsOut, .cmdDwords, .cmdBusy, .srcData,
    .srcValid, .srcReady, .sinkData, .sinkValid, .sinkReady, .sinkReadyForFrame, .deviceError,
    .txDataReq, .txDataInfo, .txData, .txDataValid, .txDataReady, .txDataDone, .txActReq,
    .txActDone, .rxData, .rxValid, .rxReady, .rxDone, .rxError, .txStatusReq, .txStatusInfo,
    .txStatusDone);
  dcp_transport_model host (.clk_sys, .reset, .txDataReq, .txDataInfo, .txData, .txDataValid,
    .txDataReady, .txDataDone, .txActReq, .txActDone, .rxData, .rxValid, .rxReady, .rxDone,
    .rxError, .txStatusReq, .txStatusInfo, .txStatusDone, .rxLen, .rxErrInject, .dataWords,
    .frames, .maxLen,
    .actCount, .statusCount, .lastTx, .lastStatus);
  // ------------------------------------------------------------
  // Media side: counted source, stalling sink checked in order
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srcValid && srcReady) srcTaken <= srcTaken + 1;
    if (sinkValid && sinkReady) begin
      if (sinkData !== 32'hA5000000 + sinkCnt) sinkBad <= sinkBad + 1;
      sinkCnt <= sinkCnt + 1;
    end
  end
  always @(negedge clk_sys) begin
    srcData <= 32'hC0DE0000 + srcTaken;
    sinkReady <= ~sinkReady;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic start_cmd(logic isOut, logic [31:0] dw);
    @(negedge clk_sys);
    cmdStart = 1'b1;
    cmdIsOut = isOut;
    cmdDwords = dw;
    @(negedge clk_sys);
    cmdStart = 1'b0;
  endtask : start_cmd
  // Bounded wait so a stuck machine ends as a mismatch
  task automatic wait_idle();
    int n;
    for (n = 0; n < 12000 && cmdBusy !== 1'b0; n++) @(negedge clk_sys);
    chk("idle reached", 32'h1, {31'h0, cmdBusy === 1'b0});
  endtask : wait_idle
  task automatic chk_status(int prev, logic [7:0] st, logic [7:0] er);
    chk("status frames", prev + 1, statusCount);
    chk("interrupt bit", 32'h1, {31'h0, lastStatus.intBit});
    chk("status code", {24'h0, st}, {24'h0, lastStatus.status});
    chk("error field", {24'h0, er}, {24'h0, lastStatus.error});
  endtask : chk_status
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_in_short();
    int w0 = dataWords, s0 = statusCount;
    srcValid = 1'b1;
    start_cmd(1'b0, 32'h3);
    wait_idle();
    chk("inbound words", 32'h3, dataWords - w0);
    chk("last word", 32'hC0DE0000 + srcTaken - 1, lastTx);
    chk_status(s0, 8'h50, 8'h00);
    $display("test in_short done");
  endtask : t_in_short
  task automatic t_in_long();
    int w0 = dataWords, f0 = frames, s0 = statusCount;
    start_cmd(1'b0, 32'h802);
    wait_idle();
    chk("inbound words", 32'h802, dataWords - w0);
    chk("frame count", 32'h2, frames - f0);
    chk("largest frame", 32'h800, maxLen);
    chk_status(s0, 8'h50, 8'h00);
    $display("test in_long done");
  endtask : t_in_long
  task automatic t_out();
    int a0 = actCount, s0 = statusCount, k0 = sinkCnt;
    sinkReadyForFrame = 1'b0;
    start_cmd(1'b1, 32'h4);
    repeat (12) @(negedge clk_sys);
    chk("early activation", 32'h0, actCount - a0);
    chk("early status", 32'h0, statusCount - s0);
    sinkReadyForFrame = 1'b1;
    wait_idle();
    repeat (10) @(negedge clk_sys);
    chk("activations", 32'h1, actCount - a0);
    chk("sink words", 32'h4, sinkCnt - k0);
    chk("sink order", 32'h0, sinkBad);
    chk_status(s0, 8'h50, 8'h00);
    $display("test out done");
  endtask : t_out
  task automatic t_abort();
    int w0 = dataWords, s0 = statusCount;
    srcValid = 1'b0;
    start_cmd(1'b0, 32'h8);
    repeat (5) @(negedge clk_sys);
    chk("prepare held", 32'h0, statusCount - s0);
    // Error rises with the source data so it lands inside the send state
    srcValid = 1'b1;
    deviceError = 1'b1;
    wait_idle();
    deviceError = 1'b0;
    chk("aborted words", 32'h0, dataWords - w0);
    chk_status(s0, 8'h51, 8'h04);
    $display("test abort done");
  endtask : t_abort
  task automatic t_out_abort();
    int a0 = actCount, s0 = statusCount, k0 = sinkCnt, n;
    start_cmd(1'b1, 32'h8);
    for (n = 0; n < 20 && rxValid !== 1'b1; n++) @(negedge clk_sys);
    // Host fault on the first word of the frame
    rxErrInject = 1'b1;
    @(negedge clk_sys);
    rxErrInject = 1'b0;
    wait_idle();
    repeat (10) @(negedge clk_sys);
    chk("aborted activations", 32'h1, actCount - a0);
    chk("aborted sink words", 32'h1, sinkCnt - k0);
    chk("aborted sink order", 32'h0, sinkBad);
    chk_status(s0, 8'h51, 8'h04);
    $display("test out_abort done");
  endtask : t_out_abort
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    t_in_short();
    t_in_long();
    t_out();
    t_abort();
    t_out_abort();
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of about 4200 cycles
  initial begin
    #(50 * 30000);
    miscompares++;
    tally_and_finish();
  end
endmodule : testbench
